//--- core/tfca_core.sv
// Functional notes
// RULE_01 - readback bit 6 low during media write
// RULE_02 - readback bits 5:2 are inverted head
// RULE_03 - readback bit 1 low: unit 1 selected
// RULE_04 - readback bit 0 low: unit 0 selected
// RULE_05 - host loads parameters before opcode
// RULE_06 - host issues commands only when idle
// RULE_07 - class 1: busy within 400ns
// RULE_08 - class 2: drq by 700us, busy drops
// RULE_09 - class 3: drq by 20ms, busy drops
// RULE_10 - legacy opcodes complete as nop
// RULE_11 - use only parameters valid for opcode
// RULE_12 - 98h/E5h decode as power query
// RULE_13 - standby query: count zero, irq
// RULE_14 - idle query: count all ones, irq
// RULE_15 - erase conditions sectors for later writes
// RULE_16 - erase has no data, may write-fault
// RULE_17 - erase address from task file, lba
// RULE_18 - CDh multi write without erase
// RULE_19 - 38h single write without erase
// RULE_20 - F8h returns native max address; the core only starts the media side and loads no address back
// RULE_21 - busy on status bit 7, locks host
// RULE_22 - unit head bit 4 selects unit
// RULE_23 - count of zero means 256
// RULE_24 - unknown opcode aborts with error
`timescale 1ns/100ps
module tfca_core
	import tfca_pkg::*;
#(
	parameter int DRQ2_LIM = DRQ2_CYC,
	parameter int DRQ3_LIM = DRQ3_CYC
) (
	input  wire logic       clk_sys_i,
	input  wire logic       nrst_i,
	input  wire logic [3:0] addr_i,
	input  wire logic       wr_i,
	input  wire logic       rd_i,
	input  wire logic [7:0] wdata_i,
	input  wire logic       unit_id_i,
	input  wire logic       pwr_idle_i,
	input  wire logic       media_wr_i,
	input  wire logic       buf_rdy_i,
	input  wire logic       done_i,
	input  wire logic       fault_i,
	output logic [7:0]      rd_data_o,
	output logic            irq_o,
	output logic            cmd_start_o,
	output tfca_cmd_t       cmd_o
);
	// ---------------------------------------------------------------
	// task file state
	// ---------------------------------------------------------------
	logic [7:0] feat_q, cnt_q, sec_q, cyll_q, cylh_q, uh_q;
	logic       busy_q, drq_q, err_q, dwf_q, abrt_q, rdy_q;
	logic       srst_q, nien_q, irq_q, unit_id_q, strap_q;
	tfca_st_t   st_q;
	tfca_dec_t  dec;
	logic       tmr_due;

	tfca_dec u_dec (
		.opcode_i (wdata_i),
		.dec_o    (dec)
	);

	// ---------------------------------------------------------------
	// host decode
	// ---------------------------------------------------------------
	wire hit_cmd  = wr_i && (addr_i == OFS_CMD);
	wire hit_ctl  = wr_i && (addr_i == OFS_CTL);
	// RULE_06 only taken while busy and soft reset are clear, drq phase included
	wire wr_cmd   = hit_cmd && !busy_q && !srst_q;
	// RULE_21 parameters locked while busy
	wire wr_par   = wr_i && !busy_q && !srst_q;
	wire rd_stat  = rd_i && (addr_i == OFS_CMD);
	wire is_local = (cmd_o.kind == K_PWR) || (cmd_o.kind == K_NOP) || (cmd_o.kind == K_ABORT);
	wire to_back  = (dec.kind != K_PWR) && (dec.kind != K_NOP) && (dec.kind != K_ABORT);
	wire wr_class = (dec.cls != CLS1);
	wire [TMR_W-1:0] lim = (dec.cls == CLS3) ? TMR_W'(DRQ3_LIM - 2) : TMR_W'(DRQ2_LIM - 2);

	// RULE_22 unit number field
	wire uh_unit  = uh_q[UH_UNIT];
	// RULE_23 zero count is 256
	wire [8:0] cnt9 = (cnt_q == BYTE_0) ? CNT_MAX : {1'b0, cnt_q};

	// RULE_11 only valid parameters pass
	wire [3:0]  head_v = dec.use_head ? uh_q[3:0] : 4'h0;
	wire [7:0]  sec_v  = dec.use_sn ? sec_q : BYTE_0;
	wire [15:0] cyl_v  = dec.use_cy ? {cylh_q, cyll_q} : {BYTE_0, BYTE_0};
	// RULE_17 lba or chs start address
	wire [27:0] addr_v = {head_v, cyl_v, sec_v};
	wire        lba_v  = dec.use_lba & uh_q[UH_LBA];

	tfca_cmd_t cmd_d;
	assign cmd_d = '{opcode: wdata_i, kind: dec.kind,
	                 feature: dec.use_fr ? feat_q : BYTE_0,
	                 count: dec.use_sc ? cnt9 : 9'h000,
	                 lba: lba_v, addr: addr_v, unit: uh_unit};

	tfca_tmr u_tmr (
		.clk_sys_i (clk_sys_i),
		.nrst_i    (nrst_i),
		.load_i    (wr_cmd && wr_class),
		.limit_i   (lim),
		.due_o     (tmr_due)
	);

	// ---------------------------------------------------------------
	// readback and status
	// ---------------------------------------------------------------
	wire [7:0] stat = {busy_q, rdy_q, dwf_q, rdy_q, drq_q, 1'b0, 1'b0, err_q};
	wire [7:0] rb;
	// RULE_01 write in progress bit
	assign rb[RB_WIP] = ~media_wr_i;
	// RULE_02 inverted head bits
	assign rb[5:2] = ~uh_q[3:0];
	// RULE_03 unit 1 active and selected
	assign rb[RB_U1] = ~(unit_id_q & uh_unit);
	// RULE_04 unit 0 active and selected
	assign rb[RB_U0] = ~(~unit_id_q & ~uh_unit);
	// bit 7 reads low to stay off a shared line
	assign rb[7] = 1'b0;

	logic [7:0] rmux;
	always_comb begin
		unique case (addr_i)
			OFS_FEAT:          rmux = {5'h00, abrt_q, 2'h0};
			OFS_CNT:           rmux = cnt_q;
			OFS_SEC:           rmux = sec_q;
			OFS_CYLL:          rmux = cyll_q;
			OFS_CYLH:          rmux = cylh_q;
			OFS_UH:            rmux = uh_q;
			OFS_CMD, OFS_CTL:  rmux = stat;
			OFS_ADDR:          rmux = rb;
			default:           rmux = BYTE_0;
		endcase
	end

	// ---------------------------------------------------------------
	// command sequencing
	// ---------------------------------------------------------------
	wire exec_end = (st_q == S_EXEC) && (is_local || done_i);
	wire prep_end = (st_q == S_PREP) && (buf_rdy_i || tmr_due);
	wire xfer_end = (st_q == S_XFER) && done_i;
	wire cmd_end  = exec_end || xfer_end;
	wire irq_set  = cmd_end && !srst_q;
	wire irq_d    = irq_set | (irq_q & ~rd_stat);

	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			st_q <= S_IDLE;
			busy_q <= 1'b0;
			drq_q <= 1'b0;
		end else if (srst_q) begin
			st_q <= S_IDLE;
			busy_q <= 1'b1;
			drq_q <= 1'b0;
		end else begin
			unique case (st_q)
				S_IDLE: begin
					// RULE_07 busy on next edge
					if (wr_cmd) begin
						st_q <= wr_class ? S_PREP : S_EXEC;
						busy_q <= 1'b1;
					end else begin
						busy_q <= 1'b0;
					end
				end
				S_EXEC: begin
					if (exec_end) begin
						st_q <= S_IDLE;
						busy_q <= 1'b0;
					end
				end
				S_PREP: begin
					// RULE_08 drq by deadline, busy drops
					// RULE_09 same edge for class 3
					if (prep_end) begin
						st_q <= S_XFER;
						drq_q <= 1'b1;
						busy_q <= 1'b0;
					end
				end
				S_XFER: begin
					if (xfer_end) begin
						st_q <= S_IDLE;
						drq_q <= 1'b0;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			err_q <= 1'b0;
			dwf_q <= 1'b0;
			abrt_q <= 1'b0;
		end else if (srst_q || wr_cmd) begin
			err_q <= 1'b0;
			dwf_q <= 1'b0;
			abrt_q <= 1'b0;
		// RULE_24 unknown opcode aborts
		end else if (exec_end && cmd_o.kind == K_ABORT) begin
			err_q <= 1'b1;
			abrt_q <= 1'b1;
		// RULE_16 erase may end write-faulted
		end else if (cmd_end && !is_local && fault_i) begin
			err_q <= 1'b1;
			dwf_q <= 1'b1;
		end
	end

	// ---------------------------------------------------------------
	// parameter registers
	// ---------------------------------------------------------------
	// RULE_05 opcode captures loaded parameters
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			feat_q <= BYTE_0;
			sec_q <= BYTE_0;
			cyll_q <= BYTE_0;
			cylh_q <= BYTE_0;
			uh_q <= UH_RST;
		end else if (wr_par) begin
			if (addr_i == OFS_FEAT) feat_q <= wdata_i;
			if (addr_i == OFS_SEC) sec_q <= wdata_i;
			if (addr_i == OFS_CYLL) cyll_q <= wdata_i;
			if (addr_i == OFS_CYLH) cylh_q <= wdata_i;
			if (addr_i == OFS_UH) uh_q <= wdata_i;
		end
	end

	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cnt_q <= CNT_RST;
		// RULE_13 standby query loads zero
		// RULE_14 idle query loads all ones
		end else if (exec_end && cmd_o.kind == K_PWR && !srst_q) begin
			cnt_q <= pwr_idle_i ? BYTE_1 : BYTE_0;
		end else if (wr_par && addr_i == OFS_CNT) begin
			cnt_q <= wdata_i;
		end
	end

	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cmd_o <= '0;
			cmd_start_o <= 1'b0;
		end else begin
			if (wr_cmd) cmd_o <= cmd_d;
			// RULE_10 nop never reaches media
			// RULE_15 erase handed to media side
			cmd_start_o <= wr_cmd && to_back;
		end
	end

	// ---------------------------------------------------------------
	// control, strap, interrupt, read data
	// ---------------------------------------------------------------
	// strap caught after release, never under reset
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			srst_q <= 1'b0;
			nien_q <= 1'b0;
			strap_q <= 1'b0;
			unit_id_q <= 1'b0;
			rdy_q <= 1'b0;
			irq_q <= 1'b0;
			irq_o <= 1'b0;
			rd_data_o <= BYTE_0;
		end else begin
			if (hit_ctl) srst_q <= wdata_i[CTL_SRST];
			if (hit_ctl) nien_q <= wdata_i[CTL_NIEN];
			strap_q <= 1'b1;
			if (!strap_q) unit_id_q <= unit_id_i;
			rdy_q <= strap_q && !srst_q;
			irq_q <= irq_d;
			irq_o <= irq_d & ~nien_q;
			if (rd_i) rd_data_o <= rmux;
		end
	end

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	wire rd_rb = rd_i && (addr_i == OFS_ADDR);

	property p_rb_wip;
		@(posedge clk_sys_i) disable iff (!nrst_i)
		rd_rb |=> rd_data_o[RB_WIP] == !$past(media_wr_i);
	endproperty
	a_rb_wip: assert property (p_rb_wip) else $error("write idle bit wrong"); // RULE_01

	property p_rb_head;
		@(posedge clk_sys_i) disable iff (!nrst_i)
		rd_rb |=> rd_data_o[5:2] == ~$past(uh_q[3:0]);
	endproperty
	a_rb_head: assert property (p_rb_head) else $error("head readback wrong"); // RULE_02

	property p_rb_u1;
		@(posedge clk_sys_i) disable iff (!nrst_i)
		rd_rb && unit_id_q && uh_unit |=> !rd_data_o[RB_U1] && rd_data_o[RB_U0];
	endproperty
	a_rb_u1: assert property (p_rb_u1) else $error("unit 1 select wrong"); // RULE_03

	property p_rb_u0;
		@(posedge clk_sys_i) disable iff (!nrst_i)
		rd_rb && !unit_id_q && !uh_unit |=> !rd_data_o[RB_U0] && rd_data_o[RB_U1];
	endproperty
	a_rb_u0: assert property (p_rb_u0) else $error("unit 0 select wrong"); // RULE_04

	property p_busy_set;
		@(posedge clk_sys_i) disable iff (!nrst_i)
		wr_cmd |=> busy_q && !drq_q;
	endproperty
	a_busy_set: assert property (p_busy_set) else $error("busy late after opcode"); // RULE_07

	property p_drq_due;
		@(posedge clk_sys_i) disable iff (!nrst_i)
		(st_q == S_PREP) && tmr_due && !srst_q |=> drq_q && !busy_q;
	endproperty
	a_drq_due: assert property (p_drq_due) else $error("drq missed deadline"); // RULE_08

	property p_drq_nbsy;
		@(posedge clk_sys_i) disable iff (!nrst_i)
		$rose(drq_q) |-> !busy_q && $past(busy_q);
	endproperty
	a_drq_nbsy: assert property (p_drq_nbsy) else $error("busy held with drq"); // RULE_09

	sequence s_pwr_issue;
		wr_cmd && dec.kind == K_PWR ##1 busy_q && !srst_q;
	endsequence

	property p_pwr_stby;
		@(posedge clk_sys_i) disable iff (!nrst_i)
		s_pwr_issue ##0 !pwr_idle_i |=> !busy_q && cnt_q == BYTE_0 && irq_q;
	endproperty
	a_pwr_stby: assert property (p_pwr_stby) else $error("standby query wrong"); // RULE_13

	property p_pwr_idle;
		@(posedge clk_sys_i) disable iff (!nrst_i)
		s_pwr_issue ##0 pwr_idle_i |=> !busy_q && cnt_q == BYTE_1 && irq_q;
	endproperty
	a_pwr_idle: assert property (p_pwr_idle) else $error("idle query wrong"); // RULE_14

	property p_nop;
		@(posedge clk_sys_i) disable iff (!nrst_i)
		wr_cmd && dec.kind == K_NOP |=> !cmd_start_o ##1 !busy_q && !err_q;
	endproperty
	a_nop: assert property (p_nop) else $error("nop touched media"); // RULE_10

	property p_abort;
		@(posedge clk_sys_i) disable iff (!nrst_i)
		wr_cmd && dec.kind == K_ABORT |=> ##1 err_q && abrt_q && !busy_q;
	endproperty
	a_abort: assert property (p_abort) else $error("unknown opcode not aborted"); // RULE_24

	property p_count;
		@(posedge clk_sys_i) disable iff (!nrst_i)
		wr_cmd && dec.use_sc && cnt_q == BYTE_0 |=> cmd_o.count == CNT_MAX;
	endproperty
	a_count: assert property (p_count) else $error("zero count not 256"); // RULE_23

	property p_lock;
		@(posedge clk_sys_i) disable iff (!nrst_i)
		busy_q && wr_i && addr_i == OFS_SEC |=> $stable(sec_q);
	endproperty
	a_lock: assert property (p_lock) else $error("write taken while busy"); // RULE_21
endmodule : tfca_core

//--- core/tfca_dec.sv
`timescale 1ns/100ps
module tfca_dec
	import tfca_pkg::*;
(
	input  wire logic [7:0] opcode_i,
	output tfca_dec_t       dec_o
);
	always_comb begin
		dec_o = '{kind: K_ABORT, cls: CLS1, default: 1'b0};
		// RULE_12 power query
		if (opcode_i == OP_PWR_A || opcode_i == OP_PWR_B) begin
			dec_o.kind = K_PWR;
		// RULE_17 erase parameters
		end else if (opcode_i == OP_ERASE) begin
			dec_o = '{kind: K_ERASE, cls: CLS1, use_fr: 1'b0, default: 1'b1};
		// RULE_18 multi write no erase
		end else if (opcode_i == OP_WMNE) begin
			dec_o = '{kind: K_WMNE, cls: CLS3, use_fr: 1'b0, default: 1'b1};
		// RULE_19 single write no erase
		end else if (opcode_i == OP_WSNE) begin
			dec_o = '{kind: K_WSNE, cls: CLS2, use_fr: 1'b0, default: 1'b1};
		// RULE_20 native max address
		end else if (opcode_i == OP_NMAX) begin
			dec_o.kind = K_NMAX;
		// RULE_10 legacy nop opcodes
		end else if (opcode_i[7:4] == OP_RECAL || opcode_i[7:4] == OP_SEEK) begin
			dec_o.kind = K_NOP;
		end
	end
endmodule : tfca_dec

//--- core/tfca_pkg.sv
package tfca_pkg;
	// ---------------------------------------------------------------
	// task file offsets
	// ---------------------------------------------------------------
	localparam logic [3:0] OFS_DATA = 4'h0;
	localparam logic [3:0] OFS_FEAT = 4'h1;
	localparam logic [3:0] OFS_CNT  = 4'h2;
	localparam logic [3:0] OFS_SEC  = 4'h3;
	localparam logic [3:0] OFS_CYLL = 4'h4;
	localparam logic [3:0] OFS_CYLH = 4'h5;
	localparam logic [3:0] OFS_UH   = 4'h6;
	localparam logic [3:0] OFS_CMD  = 4'h7;
	localparam logic [3:0] OFS_CTL  = 4'he;
	localparam logic [3:0] OFS_ADDR = 4'hf;
	// ---------------------------------------------------------------
	// field positions
	// ---------------------------------------------------------------
	localparam int ST_BUSY  = 7;
	localparam int ST_RDY   = 6;
	localparam int ST_DWF   = 5;
	localparam int ST_DSC   = 4;
	localparam int ST_DRQ   = 3;
	localparam int ST_ERR   = 0;
	localparam int ER_ABRT  = 2;
	localparam int UH_LBA   = 6;
	localparam int UH_UNIT  = 4;
	localparam int CTL_SRST = 2;
	localparam int CTL_NIEN = 1;
	localparam int RB_WIP   = 6;
	localparam int RB_U1    = 1;
	localparam int RB_U0    = 0;
	// ---------------------------------------------------------------
	// reset values and constants
	// ---------------------------------------------------------------
	localparam logic [7:0] CNT_RST  = 8'h01;
	localparam logic [7:0] UH_RST   = 8'ha0;
	localparam logic [7:0] BYTE_0   = 8'h00;
	localparam logic [7:0] BYTE_1   = 8'hff;
	localparam logic [8:0] CNT_MAX  = 9'h100;
	// ---------------------------------------------------------------
	// opcodes
	// ---------------------------------------------------------------
	localparam logic [7:0] OP_PWR_A = 8'h98;
	localparam logic [7:0] OP_PWR_B = 8'he5;
	localparam logic [7:0] OP_ERASE = 8'hc0;
	localparam logic [7:0] OP_WMNE  = 8'hcd;
	localparam logic [7:0] OP_WSNE  = 8'h38;
	localparam logic [7:0] OP_NMAX  = 8'hf8;
	localparam logic [3:0] OP_RECAL = 4'h1;
	localparam logic [3:0] OP_SEEK  = 4'h7;
	// ---------------------------------------------------------------
	// timing
	// ---------------------------------------------------------------
	localparam int CLK_NS    = 8;
	localparam int T_BSY_NS  = 400;
	localparam int T_DRQ2_US = 700;
	localparam int T_DRQ3_MS = 20;
	localparam int BSY_CYC   = T_BSY_NS / CLK_NS;
	localparam int DRQ2_CYC  = T_DRQ2_US * 1000 / CLK_NS;
	localparam int DRQ3_CYC  = T_DRQ3_MS * 1000000 / CLK_NS;
	localparam int TMR_W     = 22;
	// ---------------------------------------------------------------
	// types
	// ---------------------------------------------------------------
	typedef enum logic [3:0] {
		K_ABORT, K_PWR, K_ERASE, K_NMAX, K_WSNE, K_WMNE, K_NOP
	} tfca_kind_t;
	typedef enum logic [1:0] {CLS1 = 2'h1, CLS2 = 2'h2, CLS3 = 2'h3} tfca_cls_t;
	typedef enum logic [1:0] {S_IDLE = 2'b00, S_EXEC = 2'b01, S_PREP = 2'b10, S_XFER = 2'b11} tfca_st_t;
	typedef struct packed {
		tfca_kind_t kind;
		tfca_cls_t  cls;
		logic       use_fr;
		logic       use_sc;
		logic       use_sn;
		logic       use_cy;
		logic       use_head;
		logic       use_lba;
	} tfca_dec_t;
	typedef struct packed {
		logic [7:0]  opcode;
		tfca_kind_t  kind;
		logic [7:0]  feature;
		logic [8:0]  count;
		logic        lba;
		logic [27:0] addr;
		logic        unit;
	} tfca_cmd_t;
endpackage : tfca_pkg

//--- core/tfca_tmr.sv
`timescale 1ns/100ps
module tfca_tmr
	import tfca_pkg::*;
(
	input  wire logic             clk_sys_i,
	input  wire logic             nrst_i,
	input  wire logic             load_i,
	input  wire logic [TMR_W-1:0] limit_i,
	output logic                  due_o
);
	logic [TMR_W-1:0] cnt_q;
	logic             run_q;
	wire              last = run_q && (cnt_q == '0);

	// counts down so the flag lands on the last legal cycle
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cnt_q <= '0;
			run_q <= 1'b0;
			due_o <= 1'b0;
		end else begin
			cnt_q <= load_i ? limit_i : (run_q ? cnt_q - 1'b1 : cnt_q);
			run_q <= load_i | (run_q & ~last);
			due_o <= last & ~load_i;
		end
	end
endmodule : tfca_tmr

//--- test/tfca_core_bench.sv
`timescale 1ns/100ps
module tfca_core_bench;
	import tfca_pkg::*;
	logic       clk_sys_i;
	logic       nrst_i;
	logic [3:0] addr_i;
	logic       wr_i;
	logic       rd_i;
	logic [7:0] wdata_i;
	logic       unit_id_i;
	logic       pwr_idle_i;
	logic       slow;
	logic       fmode;
	logic       media_wr;
	logic       buf_rdy;
	logic       done;
	logic       fault;
	logic [7:0] rd_data;
	logic       irq;
	logic       start;
	tfca_cmd_t  cmd;
	logic [7:0] d;
	logic [7:0] op;
	int         fail_count;
	int         n_tests;
	int         i;

	always #4 clk_sys_i = ~clk_sys_i;

	tfca_core #(.DRQ2_LIM(50), .DRQ3_LIM(80)) uut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .addr_i(addr_i),
		.wr_i(wr_i), .rd_i(rd_i), .wdata_i(wdata_i), .unit_id_i(unit_id_i), .pwr_idle_i(pwr_idle_i),
		.media_wr_i(media_wr), .buf_rdy_i(buf_rdy), .done_i(done), .fault_i(fault), .rd_data_o(rd_data),
		.irq_o(irq), .cmd_start_o(start), .cmd_o(cmd));
	tfca_media_model media (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .cmd_start_i(start), .cmd_i(cmd),
		.slow_i(slow), .fault_mode_i(fmode), .media_wr_o(media_wr), .buf_rdy_o(buf_rdy), .done_o(done),
		.fault_o(fault));

	// ---------------------------------------------------------------
	// access tasks
	// ---------------------------------------------------------------
	task test_done;
		$display("tests %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : test_done
	task chk(input logic [63:0] seen, input logic [63:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fail_count++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task give_up;
		fail_count++;
		$display("MISMATCH t=%0t wait expired", $time);
		test_done();
	endtask : give_up
	task wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge clk_sys_i);
		addr_i  <= a;
		wdata_i <= v;
		wr_i    <= 1'b1;
		@(posedge clk_sys_i);
		wr_i    <= 1'b0;
	endtask : wr
	task rd(input logic [3:0] a, output logic [7:0] v);
		@(posedge clk_sys_i);
		addr_i <= a;
		rd_i   <= 1'b1;
		@(posedge clk_sys_i);
		rd_i   <= 1'b0;
		@(posedge clk_sys_i);
		@(negedge clk_sys_i);
		v = rd_data;
	endtask : rd
	// alternate status polls busy without clearing the interrupt
	task wait_idle(output logic [7:0] st);
		int k;
		for (k = 0; k < 200; k++) begin
			rd(OFS_CTL, st);
			if (st[ST_BUSY] === 1'b0)
				return;
		end
		give_up();
	endtask : wait_idle
	task wait_irq;
		int k;
		for (k = 0; k < 300; k++) begin
			if (irq === 1'b1)
				return;
			@(posedge clk_sys_i);
		end
		give_up();
	endtask : wait_irq
	task issue(input logic [7:0] o);
		logic [7:0] st;
		wait_idle(st);
		wr(OFS_CMD, o);
	endtask : issue
	function automatic logic [7:0] rb(input logic [7:0] uh, input logic unit, input logic mw);
		rb = {1'b0, ~mw, ~uh[3:0], ~(unit & uh[UH_UNIT]), ~(~unit & ~uh[UH_UNIT])};
	endfunction : rb

	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	initial begin
		clk_sys_i = 1'b0; nrst_i = 1'b0; addr_i = 4'h0; wr_i = 1'b0; rd_i = 1'b0; wdata_i = 8'h00;
		unit_id_i = 1'b0; pwr_idle_i = 1'b1; slow = 1'b0; fmode = 1'b0; fail_count = 0; n_tests = 0;
		repeat (6) @(posedge clk_sys_i);
		nrst_i <= 1'b1;
		repeat (2) @(posedge clk_sys_i);
		rd(OFS_ADDR, d); chk(d, rb(UH_RST, 1'b0, 1'b0));
		wr(OFS_UH, 8'ha5); rd(OFS_ADDR, d); chk(d, rb(8'ha5, 1'b0, 1'b0));
		wr(OFS_UH, 8'hb0); rd(OFS_ADDR, d); chk(d, rb(8'hb0, 1'b0, 1'b0));
		for (i = 0; i < 4; i++) begin
			@(posedge clk_sys_i);
			pwr_idle_i <= i[0];
			issue(i[1] ? OP_PWR_B : OP_PWR_A);
			wait_irq();
			wait_idle(d);
			rd(OFS_CNT, d); chk(d, i[0] ? BYTE_1 : BYTE_0);
			rd(OFS_CMD, d); chk(irq, 1'b0);
		end
		// class 2, count zero, lba addressing
		wr(OFS_CNT, 8'h00); wr(OFS_SEC, 8'h11); wr(OFS_CYLL, 8'h22); wr(OFS_CYLH, 8'h33); wr(OFS_UH, 8'he5);
		issue(OP_WSNE);
		rd(OFS_CTL, d); chk(d[ST_BUSY], 1'b1);
		chk(cmd.count, CNT_MAX);
		chk({cmd.kind, cmd.lba, cmd.addr}, {K_WSNE, 1'b1, 28'h5332211});
		wr(OFS_SEC, 8'h99);
		wait_idle(d); chk(d[ST_DRQ], 1'b1);
		rd(OFS_SEC, d); chk(d, 8'h11);
		rd(OFS_ADDR, d); chk(d, rb(8'he5, 1'b0, 1'b1));
		wait_irq();
		rd(OFS_CMD, d); chk(d[ST_DRQ], 1'b0);
		// class 3 with the buffer never ready: deadline forces drq
		@(posedge clk_sys_i);
		slow <= 1'b1;
		issue(OP_WMNE);
		@(negedge clk_sys_i);
		chk(cmd.kind, K_WMNE);
		wait_idle(d); chk(d[ST_DRQ], 1'b1);
		wait_irq();
		rd(OFS_CMD, d);
		// erase in chs mode ending in a write fault
		@(posedge clk_sys_i);
		slow  <= 1'b0;
		fmode <= 1'b1;
		wr(OFS_CNT, 8'h03); wr(OFS_UH, 8'ha2);
		issue(OP_ERASE);
		rd(OFS_CTL, d); chk(d[ST_BUSY], 1'b1);
		chk({cmd.kind, cmd.lba, cmd.count, cmd.addr}, {K_ERASE, 1'b0, 9'h003, 28'h2332211});
		wait_irq();
		rd(OFS_CMD, d); chk({d[ST_DWF], d[ST_ERR]}, 2'b11);
		// only the unit field counts: head and count dropped
		@(posedge clk_sys_i);
		fmode <= 1'b0;
		wr(OFS_UH, 8'ha7);
		issue(OP_NMAX);
		@(negedge clk_sys_i);
		chk(start, 1'b1);
		chk({cmd.kind, cmd.count, cmd.addr}, {K_NMAX, 9'h000, 28'h0000000});
		wait_irq();
		rd(OFS_CMD, d); chk(d[ST_ERR], 1'b0);
		// legacy no-ops, then an unsupported opcode
		for (i = 0; i < 3; i++) begin
			op = (i == 0) ? 8'h10 : (i == 1) ? 8'h7f : 8'h20;
			issue(op);
			wait_idle(d);
			rd(OFS_CMD, d); chk(d[ST_ERR], i == 2);
			rd(OFS_FEAT, d); chk(d[ER_ABRT], i == 2);
		end
		// soft reset holds busy; masked interrupt stays low until unmasked
		wr(OFS_CTL, 8'h06); rd(OFS_CTL, d); chk(d[ST_BUSY], 1'b1);
		wr(OFS_CTL, 8'h02); issue(OP_PWR_A); wait_idle(d); chk(irq, 1'b0);
		wr(OFS_CTL, 8'h00);
		@(negedge clk_sys_i);
		@(negedge clk_sys_i);
		chk(irq, 1'b1);
		rd(OFS_CMD, d); chk(d[ST_RDY], 1'b1);
		// second reset in mid-run as unit 1
		@(posedge clk_sys_i);
		nrst_i    <= 1'b0;
		unit_id_i <= 1'b1;
		repeat (3) @(posedge clk_sys_i);
		nrst_i <= 1'b1;
		repeat (2) @(posedge clk_sys_i);
		rd(OFS_CTL, d); chk(d[ST_RDY], 1'b1);
		rd(OFS_ADDR, d); chk(d, rb(UH_RST, 1'b1, 1'b0));
		wr(OFS_UH, 8'hb3); rd(OFS_ADDR, d); chk(d, rb(8'hb3, 1'b1, 1'b0));
		test_done();
	end
endmodule : tfca_core_bench

//--- test/tfca_media_model.sv
`timescale 1ns/100ps
module tfca_media_model
	import tfca_pkg::*;
(
	input  wire logic      clk_sys_i,
	input  wire logic      nrst_i,
	input  wire logic      cmd_start_i,
	input  wire tfca_cmd_t cmd_i,
	input  wire logic      slow_i,
	input  wire logic      fault_mode_i,
	output logic           media_wr_o,
	output logic           buf_rdy_o,
	output logic           done_o,
	output logic           fault_o
);
	// ---------------------------------------------------------------
	// media side: one job at a time, fixed latencies
	// ---------------------------------------------------------------
	logic [7:0] cnt_q;
	logic       act_q;
	logic       wr_q;
	// slow write job never readies the buffer: forces the drq deadline
	wire  [7:0] end_w = wr_q ? (slow_i ? 8'h78 : 8'h3c) : 8'h14;
	wire        dat_w = act_q & wr_q & ~slow_i & (cnt_q >= 8'h0a);
	assign buf_rdy_o  = dat_w;
	assign media_wr_o = dat_w;
	assign done_o     = act_q & (cnt_q == end_w);
	// fault only meaningful with done; toggles while a job counts, holds when idle
	assign fault_o    = done_o ? fault_mode_i : cnt_q[0];
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			act_q <= 1'b0;
			cnt_q <= 8'h00;
			wr_q  <= 1'b0;
		end else if (cmd_start_i) begin
			act_q <= 1'b1;
			cnt_q <= 8'h00;
			wr_q  <= (cmd_i.kind == K_WSNE) || (cmd_i.kind == K_WMNE);
		end else if (act_q) begin
			cnt_q <= cnt_q + 8'h01;
			act_q <= ~done_o;
		end
	end
endmodule : tfca_media_model
